// [logic/lcr_pkg.sv]
// constants and carrier types for the vendor link configuration register bank
// assumes a 10 MHz core clock and dword-aligned configuration accesses
`default_nettype none

package lcr_pkg;

  // configuration byte offsets
  localparam logic [7:0] OFS_SUBSYS_STD = 8'h2C;
  localparam logic [7:0] OFS_SUBSYS_ALIAS = 8'hD0;
  localparam logic [7:0] OFS_EXIT_LAT = 8'hD4;
  localparam logic [7:0] OFS_ENTRY_TMR = 8'hD8;

  // reset values
  localparam logic [31:0] RST_SUBSYS_ALIAS = 32'h0000_0000;
  localparam logic [31:0] RST_EXIT_LAT = 32'h0000_0D9B;
  localparam logic [31:0] RST_ENTRY_TMR = 32'h0000_001B;

  // implemented widths; bits above read as zero
  localparam int EXIT_LAT_W = 12;
  localparam int ENTRY_TMR_W = 6;

  // field positions in the exit latency register
  localparam int DEEP_ASYNC_LSB = 9;
  localparam int DEEP_SHARED_LSB = 6;
  localparam int LIGHT_ASYNC_LSB = 3;
  localparam int LIGHT_SHARED_LSB = 0;
  // field positions in the entry timer register
  localparam int DEEP_TMR_LSB = 3;
  localparam int LIGHT_TMR_LSB = 0;
  // subsystem alias halves
  localparam int PRODUCT_LSB = 16;
  localparam int MAKER_LSB = 0;

  // timing: the core clock and timer units
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int TIMER_UNIT_US = 1;
  localparam int CYCLES_PER_UNIT = (CLK_FREQ_HZ / 1_000_000) * TIMER_UNIT_US;
  localparam int TMR_CNT_W = 16;

  // register selection
  typedef enum logic [1:0] {
    LCR_SEL_NONE = 2'b00,
    LCR_SEL_ALIAS = 2'b01,
    LCR_SEL_EXIT = 2'b10,
    LCR_SEL_ENTRY = 2'b11
  } lcr_sel_t;

  // one configuration access from the root complex
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } lcr_cfg_req_t;

  // answer to a configuration access
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } lcr_cfg_rsp_t;

endpackage

`default_nettype wire

// [logic/lcr_link_config_regs.sv]
// vendor link configuration register bank: subsystem alias, exit latencies, entry timers
// assumes synchronous configuration requests and link idle status on the core clock
// assumes perst_n and the global reset pin are already synchronous to clk
// assumes the link control bit and idle status are steady levels, not pulses
`timescale 1ns/1ps
`default_nettype none

module lcr_link_config_regs (
  input wire logic clk,
  input wire logic resetn,
  input wire logic perst_n,
  input wire logic global_reset_pin_n,
  input wire lcr_pkg::lcr_cfg_req_t cfg_req,
  output lcr_pkg::lcr_cfg_rsp_t cfg_rsp,
  input wire logic common_refclk_flag,
  input wire logic link_idle,
  output logic [15:0] subsys_product_alias,
  output logic [15:0] subsys_maker_alias,
  output logic [2:0] linkcap_deep_idle_exit,
  output logic [2:0] linkcap_light_idle_exit,
  output logic light_idle_entry_req,
  output logic deep_idle_entry_req
);

  // decode a configuration byte offset to a register of this bank
  function automatic lcr_pkg::lcr_sel_t decode_sel(input logic [7:0] addr);
    case ({addr[7:2], 2'b00})
      lcr_pkg::OFS_SUBSYS_ALIAS: decode_sel = lcr_pkg::LCR_SEL_ALIAS;
      lcr_pkg::OFS_EXIT_LAT: decode_sel = lcr_pkg::LCR_SEL_EXIT;
      lcr_pkg::OFS_ENTRY_TMR: decode_sel = lcr_pkg::LCR_SEL_ENTRY;
      default: decode_sel = lcr_pkg::LCR_SEL_NONE;
    endcase
  endfunction

  // merge write data into a register under byte enables
  function automatic logic [31:0] merge_be(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    merge_be = res;
  endfunction

  // L0s entry time in microseconds: code plus one (011 gives 4)
  function automatic logic [lcr_pkg::TMR_CNT_W-1:0] light_limit(
    input logic [2:0] code
  );
    light_limit = lcr_pkg::TMR_CNT_W'((32'(code) + 32'd1) * 32'(lcr_pkg::CYCLES_PER_UNIT));
  endfunction

  // L1 entry time in microseconds: two to the code (011 gives 8)
  function automatic logic [lcr_pkg::TMR_CNT_W-1:0] deep_limit(
    input logic [2:0] code
  );
    deep_limit = lcr_pkg::TMR_CNT_W'((32'd1 << code) * 32'(lcr_pkg::CYCLES_PER_UNIT));
  endfunction

  // power-on reset released through two flops
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // fundamental reset and global reset pin clear synchronously
  logic soft_clear;
  assign soft_clear = !perst_n || !global_reset_pin_n;

  // stored register state; unused upper bits are never kept
  logic [31:0] alias_reg;
  logic [lcr_pkg::EXIT_LAT_W-1:0] exit_reg;
  logic [lcr_pkg::ENTRY_TMR_W-1:0] entry_reg;
  logic [31:0] next_alias;
  logic [31:0] next_exit;
  logic [31:0] next_entry;
  lcr_pkg::lcr_sel_t req_sel;
  logic wr_hit;

  assign req_sel = decode_sel(cfg_req.addr);
  assign wr_hit = cfg_req.valid && cfg_req.write;

  // one write strobe per register; the mirror at 2Ch has none, so writes there drop
  logic wr_alias;
  logic wr_exit;
  logic wr_entry;
  assign wr_alias = wr_hit && req_sel == lcr_pkg::LCR_SEL_ALIAS;
  assign wr_exit = wr_hit && req_sel == lcr_pkg::LCR_SEL_EXIT;
  assign wr_entry = wr_hit && req_sel == lcr_pkg::LCR_SEL_ENTRY;

  // the standard subsystem word is read-only here
  logic std_hit;
  assign std_hit = {cfg_req.addr[7:2], 2'b00} == lcr_pkg::OFS_SUBSYS_STD;

  // merged write data for each register
  assign next_alias = merge_be(alias_reg, cfg_req.wdata, cfg_req.byte_en);
  assign next_exit = merge_be({20'h00000, exit_reg}, cfg_req.wdata, cfg_req.byte_en);
  assign next_entry = merge_be({26'h0000000, entry_reg}, cfg_req.wdata, cfg_req.byte_en);

  // subsystem alias register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alias_reg <= lcr_pkg::RST_SUBSYS_ALIAS;
    end else if (soft_clear) begin
      alias_reg <= lcr_pkg::RST_SUBSYS_ALIAS;
    end else if (wr_alias) begin
      alias_reg <= next_alias;
    end
  end

  // exit latency register, upper bits not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exit_reg <= lcr_pkg::RST_EXIT_LAT[lcr_pkg::EXIT_LAT_W-1:0];
    end else if (soft_clear) begin
      exit_reg <= lcr_pkg::RST_EXIT_LAT[lcr_pkg::EXIT_LAT_W-1:0];
    end else if (wr_exit) begin
      exit_reg <= next_exit[lcr_pkg::EXIT_LAT_W-1:0];
    end
  end

  // entry timer register, upper bits not stored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_reg <= lcr_pkg::RST_ENTRY_TMR[lcr_pkg::ENTRY_TMR_W-1:0];
    end else if (soft_clear) begin
      entry_reg <= lcr_pkg::RST_ENTRY_TMR[lcr_pkg::ENTRY_TMR_W-1:0];
    end else if (wr_entry) begin
      entry_reg <= next_entry[lcr_pkg::ENTRY_TMR_W-1:0];
    end
  end

  // read data mux; the standard subsystem word at 2Ch shows the alias
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (req_sel)
      lcr_pkg::LCR_SEL_ALIAS: rd_mux = alias_reg;
      lcr_pkg::LCR_SEL_EXIT: rd_mux = {20'h00000, exit_reg};
      lcr_pkg::LCR_SEL_ENTRY: rd_mux = {26'h0000000, entry_reg};
      default: begin
        if (std_hit) begin
          rd_mux = alias_reg;
        end
      end
    endcase
  end

  // one-cycle answer to every access, data only on reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack <= cfg_req.valid;
      cfg_rsp.rdata <= (cfg_req.valid && !cfg_req.write) ? rd_mux : 32'h0000_0000;
    end
  end

  // standard subsystem identifier follows the upper alias half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_product_alias <= 16'h0000;
    end else begin
      subsys_product_alias <= alias_reg[lcr_pkg::PRODUCT_LSB +: 16];
    end
  end

  // standard subsystem vendor identifier follows the lower alias half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      subsys_maker_alias <= 16'h0000;
    end else begin
      subsys_maker_alias <= alias_reg[lcr_pkg::MAKER_LSB +: 16];
    end
  end

  // exit latency fields as stored
  logic [2:0] deep_idle_exit_async;
  logic [2:0] deep_idle_exit_shared;
  logic [2:0] light_idle_exit_async;
  logic [2:0] light_idle_exit_shared;
  assign deep_idle_exit_async = exit_reg[lcr_pkg::DEEP_ASYNC_LSB +: 3];
  assign deep_idle_exit_shared = exit_reg[lcr_pkg::DEEP_SHARED_LSB +: 3];
  assign light_idle_exit_async = exit_reg[lcr_pkg::LIGHT_ASYNC_LSB +: 3];
  assign light_idle_exit_shared = exit_reg[lcr_pkg::LIGHT_SHARED_LSB +: 3];

  // deep idle exit latency reported, chosen by the common clock bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkcap_deep_idle_exit <= 3'h0;
    end else if (common_refclk_flag) begin
      linkcap_deep_idle_exit <= deep_idle_exit_shared;
    end else begin
      linkcap_deep_idle_exit <= deep_idle_exit_async;
    end
  end

  // light idle exit latency reported, chosen by the common clock bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      linkcap_light_idle_exit <= 3'h0;
    end else if (common_refclk_flag) begin
      linkcap_light_idle_exit <= light_idle_exit_shared;
    end else begin
      linkcap_light_idle_exit <= light_idle_exit_async;
    end
  end

  // entry timer limits from the entry timer register
  logic [lcr_pkg::TMR_CNT_W-1:0] light_lim;
  logic [lcr_pkg::TMR_CNT_W-1:0] deep_lim;
  assign light_lim = light_limit(entry_reg[lcr_pkg::LIGHT_TMR_LSB +: 3]);
  assign deep_lim = deep_limit(entry_reg[lcr_pkg::DEEP_TMR_LSB +: 3]);

  // idle counts and their next values
  logic [lcr_pkg::TMR_CNT_W-1:0] light_cnt;
  logic [lcr_pkg::TMR_CNT_W-1:0] deep_cnt;
  logic [lcr_pkg::TMR_CNT_W-1:0] next_light_cnt;
  logic [lcr_pkg::TMR_CNT_W-1:0] next_deep_cnt;

  // light count saturates at its limit so it cannot wrap
  always_comb begin
    next_light_cnt = light_cnt;
    if (light_cnt < light_lim) begin
      next_light_cnt = light_cnt + 1'b1;
    end
  end

  // deep count saturates at its limit so it cannot wrap
  always_comb begin
    next_deep_cnt = deep_cnt;
    if (deep_cnt < deep_lim) begin
      next_deep_cnt = deep_cnt + 1'b1;
    end
  end

  // light idle counter: runs while idle, restarts on any traffic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light_cnt <= '0;
    end else if (!link_idle || soft_clear) begin
      light_cnt <= '0;
    end else begin
      light_cnt <= next_light_cnt;
    end
  end

  // deep idle counter: runs while idle, restarts on any traffic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_cnt <= '0;
    end else if (!link_idle || soft_clear) begin
      deep_cnt <= '0;
    end else begin
      deep_cnt <= next_deep_cnt;
    end
  end

  // light entry request held while idle persists after expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light_idle_entry_req <= 1'b0;
    end else begin
      light_idle_entry_req <= link_idle && !soft_clear && light_cnt >= light_lim;
    end
  end

  // deep entry request held while idle persists after expiry
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_idle_entry_req <= 1'b0;
    end else begin
      deep_idle_entry_req <= link_idle && !soft_clear && deep_cnt >= deep_lim;
    end
  end

endmodule

`default_nettype wire

// [dv/lcr_link_config_regs_assertions.sv]
// checker for the link configuration register bank
// sees only the top module ports; bound after the module
`timescale 1ns/1ps
`default_nettype none
module lcr_link_config_regs_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic perst_n,
  input wire logic global_reset_pin_n,
  input wire lcr_pkg::lcr_cfg_req_t cfg_req,
  input wire lcr_pkg::lcr_cfg_rsp_t cfg_rsp,
  input wire logic common_refclk_flag,
  input wire logic link_idle,
  input wire logic [15:0] subsys_product_alias,
  input wire logic [15:0] subsys_maker_alias,
  input wire logic [2:0] linkcap_deep_idle_exit,
  input wire logic [2:0] linkcap_light_idle_exit,
  input wire logic light_idle_entry_req,
  input wire logic deep_idle_entry_req
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic run, wr_alias, rd_d4, rd_d8;
  // decoded accesses; run is low while a clear is held
  assign run = perst_n && global_reset_pin_n;
  assign wr_alias = run && cfg_req.valid && cfg_req.write && cfg_req.byte_en == 4'hF
    && cfg_req.addr[7:2] == 6'h34;
  assign rd_d4 = cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == 6'h35;
  assign rd_d8 = cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == 6'h36;
  product_mirror_a: assert property (wr_alias ##1 run |=>
    subsys_product_alias == $past(cfg_req.wdata[31:16], 2)) else $error("product alias wrong");
  maker_mirror_a: assert property (wr_alias ##1 run |=>
    subsys_maker_alias == $past(cfg_req.wdata[15:0], 2)) else $error("maker alias wrong");
  deep_exit_a: assert property (rd_d4 |=> linkcap_deep_idle_exit ==
    ($past(common_refclk_flag) ? cfg_rsp.rdata[8:6] : cfg_rsp.rdata[11:9]))
    else $error("deep exit latency wrong");
  light_exit_a: assert property (rd_d4 |=> linkcap_light_idle_exit ==
    ($past(common_refclk_flag) ? cfg_rsp.rdata[2:0] : cfg_rsp.rdata[5:3]))
    else $error("light exit latency wrong");
  exit_high_zero_a: assert property (rd_d4 |=> cfg_rsp.ack && cfg_rsp.rdata[31:12] == 20'h0)
    else $error("exit register high bits set");
  timer_high_zero_a: assert property (rd_d8 |=> cfg_rsp.ack && cfg_rsp.rdata[31:6] == 26'h0)
    else $error("timer register high bits set");
  clear_alias_a: assert property (!run ##1 !run |=> subsys_product_alias == 16'h0
    && subsys_maker_alias == 16'h0) else $error("alias not cleared");
  idle_drop_a: assert property (!link_idle |=> !light_idle_entry_req
    && !deep_idle_entry_req) else $error("entry request without idle");
  idle_entry_a: assert property ($rose(light_idle_entry_req) || $rose(deep_idle_entry_req)
    |-> $past(link_idle) && $past(link_idle, 8)) else $error("entry request too early");
endmodule
bind lcr_link_config_regs lcr_link_config_regs_assertions lcr_link_config_regs_assertions_i (
  .clk(clk), .resetn(resetn), .perst_n(perst_n), .global_reset_pin_n(global_reset_pin_n),
  .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .common_refclk_flag(common_refclk_flag),
  .link_idle(link_idle), .subsys_product_alias(subsys_product_alias),
  .subsys_maker_alias(subsys_maker_alias), .linkcap_deep_idle_exit(linkcap_deep_idle_exit),
  .linkcap_light_idle_exit(linkcap_light_idle_exit),
  .light_idle_entry_req(light_idle_entry_req), .deep_idle_entry_req(deep_idle_entry_req));
`default_nettype wire

// [dv/lcr_root_model.sv]
// root complex model issuing configuration accesses
// each call presents one access or quiet cycle at the next rising edge
`timescale 1ns/1ps
`default_nettype none
module lcr_root_model (
  input wire logic clk,
  output lcr_pkg::lcr_cfg_req_t cfg_req
);
  initial cfg_req = '0;
  // one request for one edge; quiet cycles carry random write data
  task automatic acc(input logic v, input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cfg_req <= '{v, w, a, 4'hF, d};
  endtask
endmodule
`default_nettype wire

// [dv/lcr_link_config_regs_bench.sv]
// self-checking bench for the link configuration register bank
// accesses go through the root complex model; one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
module lcr_link_config_regs_bench;
  logic clk, resetn, perst_n, global_reset_pin_n_n, ccf, idle, light_rq, deep_rq;
  lcr_pkg::lcr_cfg_req_t req;
  lcr_pkg::lcr_cfg_rsp_t rsp;
  logic [15:0] prod, maker;
  logic [2:0] deep_x, light_x;
  logic [31:0] q[$];
  logic [31:0] v;
  int failures, tests_run, n;
  lcr_link_config_regs lcr_link_config_regs_i (.clk(clk), .resetn(resetn), .perst_n(perst_n),
    .global_reset_pin_n(global_reset_pin_n_n), .cfg_req(req), .cfg_rsp(rsp), .common_refclk_flag(ccf),
    .link_idle(idle), .subsys_product_alias(prod), .subsys_maker_alias(maker),
    .linkcap_deep_idle_exit(deep_x), .linkcap_light_idle_exit(light_x),
    .light_idle_entry_req(light_rq), .deep_idle_entry_req(deep_rq));
  lcr_root_model lcr_root_model_i (.clk(clk), .cfg_req(req));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // note the expected answer, then issue the access
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    lcr_root_model_i.acc(1'b1, 1'b0, a, $urandom);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    q.push_back(32'h0);
    lcr_root_model_i.acc(1'b1, 1'b1, a, d);
  endtask
  task automatic quiet(input int c);
    repeat (c) lcr_root_model_i.acc(1'b0, 1'b0, 8'h00, $urandom);
  endtask
  // raise idle and count edges until the request shows
  task automatic tmr(input logic deep, input int e);
    n = 0;
    idle <= 1'b1;
    do begin
      @(posedge clk);
      #1 n++;
    end while (((deep ? deep_rq : light_rq) !== 1'b1) && n < 300);
    chk(n, e);
    @(posedge clk) idle <= 1'b0;
  endtask
  // every answer is compared with the oldest note
  always @(posedge clk) begin
    if (rsp.ack === 1'b1) begin
      if (q.size() > 0) chk(rsp.rdata, q.pop_front());
      else chk(32'h1, 32'h0);
    end
  end
  // cut a hang short
  initial begin
    #1_000_000;
    failures++;
    test_done();
  end
  initial begin
    {resetn, ccf, idle} = 3'h0;
    {perst_n, global_reset_pin_n_n} = 2'h3;
    failures = 0;
    tests_run = 0;
    n = $urandom(32'hD325);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    quiet(3);
    // defaults, an unmapped offset, then the mirror
    rd(8'hD0, 32'h0);
    rd(8'hD4, 32'h0000_0D9B);
    rd(8'hD8, 32'h0000_001B);
    rd(8'hC0, 32'h0);
    chk(deep_x, 32'h6);
    chk(light_x, 32'h3);
    v = $urandom;
    wr(8'hD0, v);
    wr(8'h2C, ~v);
    rd(8'h2C, v);
    quiet(2);
    #1;
    chk(prod, v[31:16]);
    chk(maker, v[15:0]);
    // each clock configuration reports its own pair
    for (int i = 0; i < 2; i++) begin
      v = $urandom;
      wr(8'hD4, v);
      ccf <= i[0];
      rd(8'hD4, {20'h0, v[11:0]});
      quiet(2);
      #1;
      chk(deep_x, i ? v[8:6] : v[11:9]);
      chk(light_x, i ? v[2:0] : v[5:3]);
    end
    v = $urandom;
    wr(8'hD8, v);
    rd(8'hD8, {26'h0, v[5:0]});
    // either clear input restores defaults and blocks writes
    for (int i = 0; i < 2; i++) begin
      wr(8'hD0, v);
      wr(8'hD4, v);
      if (i) perst_n <= 1'b0;
      else global_reset_pin_n_n <= 1'b0;
      wr(8'hD8, v);
      quiet(1);
      perst_n <= 1'b1;
      global_reset_pin_n_n <= 1'b1;
      rd(8'hD0, 32'h0);
      rd(8'hD4, 32'h0000_0D9B);
      rd(8'hD8, 32'h0000_001B);
    end
    // default timers, after idle broken before expiry
    idle <= 1'b1;
    quiet(30);
    idle <= 1'b0;
    chk(light_rq, 32'h0);
    quiet(1);
    tmr(1'b0, 41);
    quiet(2);
    tmr(1'b1, 81);
    quiet(3);
    chk(q.size(), 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
